// >>> hdl/adc_ctrl_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: byte-wide register port, one clock
// Notes:   included by the package and by every design module
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// register offsets on the plain port
`define ADC_OFF_INSEL     3'h0
`define ADC_OFF_CTRL      3'h1
`define ADC_OFF_RES_LO    3'h2
`define ADC_OFF_RES_HI    3'h3

// input select register fields
`define ADC_INSEL_REF_HI  7
`define ADC_INSEL_REF_LO  6
`define ADC_INSEL_LEFT    5
`define ADC_INSEL_CH_HI   3
`define ADC_INSEL_CH_LO   0
`define ADC_INSEL_WMASK   8'hef
`define ADC_INSEL_RST     8'h00

// control and status register fields
`define ADC_CTRL_EN       7
`define ADC_CTRL_START    6
`define ADC_CTRL_FREE     5
`define ADC_CTRL_FLAG     4
`define ADC_CTRL_IE       3
`define ADC_CTRL_PS_HI    2
`define ADC_CTRL_PS_LO    0
`define ADC_CTRL_RST      8'h00

// channel codes beyond the eight pins
`define ADC_CH_BANDGAP    4'he
`define ADC_CH_GROUND     4'hf

// conversion timing in converter clock cycles
`define ADC_CYC_NORMAL    5'd13
`define ADC_CYC_FIRST     5'd25
`define ADC_SH_NORMAL     5'd1
`define ADC_SH_FIRST      5'd13
`define ADC_SAR_MSB       10'h200

`endif

// >>> hdl/adc_ctrl_pkg.sv
// Purpose: shared types of the converter control
// Assumes: constants come from adc_ctrl_defs.svh
// Notes:   reference codes follow the reference select field
`include "adc_ctrl_defs.svh"
package adc_ctrl_pkg;
   // reference source on the reference select field
   typedef enum logic [1:0] {
      REF_EXT_PIN  = 2'h0,
      REF_SUPPLY   = 2'h1,
      REF_RESERVED = 2'h2,
      REF_INT_2V56 = 2'h3
   } ref_src_e;

   // sequencer states, one-hot
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_CONV = 2'b10
   } seq_state_e;

   typedef logic [9:0] code_t;
endpackage

// >>> hdl/conv_if.sv
// Purpose: carries timing pulses between control, prescaler, sequencer
// Assumes: all signals in the ref_clk_i domain
// Notes:   tick pulses are one cycle long
interface conv_if;
   logic       en;      // converter enable
   logic [2:0] ps;      // prescaler select
   logic       rise;    // converter clock rising edge enable
   logic       fall;    // converter clock falling edge enable
   logic       go;      // start bit pending
   logic       free;    // free-running selected
   logic       busy;    // conversion in progress
   logic       done;    // one-cycle completion pulse
   logic       last;    // final converter cycle of a conversion
   logic       hold;    // one-cycle sample-and-hold pulse
   logic       step;    // one-cycle approximation step pulse

   modport presc (input en, ps, output rise, fall);
   modport seq   (input en, rise, fall, go, free,
                  output busy, done, last, hold, step);
   modport ctrl  (output en, ps, go, free,
                  input rise, fall, busy, done, last, hold, step);
endinterface

// >>> hdl/adc_prescaler.sv
// Purpose: derives converter clock edge enables from the cpu clock
// Assumes: divide by 2,2,4,8,16,32,64,128 for select 0..7
// Notes:   counter held cleared while the converter is disabled
`include "adc_ctrl_defs.svh"
module adc_prescaler #(
   parameter int DIV_W = 7
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   // timing carrier
   conv_if.presc     c
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] top_w;
   logic [DIV_W-1:0] half_w;
   logic [2:0]       sh_w;

   if (DIV_W != 7) begin : g_chk
      $error("adc_prescaler needs DIV_W of 7");
   end

   // divide ratio minus one, and the mid point
   assign sh_w   = (c.ps == 3'h0) ? 3'h1 : c.ps;
   assign top_w  = DIV_W'((8'h01 << sh_w) - 8'h01);
   assign half_w = top_w >> 1;

   // count only while enabled, reset otherwise
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !c.en) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= (cnt_q == top_w) ? '0 : cnt_q + 1'b1;
      end
   end

   // edge enables of the converter clock
   assign c.rise = c.en && (cnt_q == top_w);
   assign c.fall = c.en && (cnt_q == half_w);
endmodule

// >>> hdl/adc_sequencer.sv
// Purpose: counts converter cycles and times hold, steps and completion
// Assumes: rise and fall pulses from adc_prescaler
// Notes:   cycle index counts rising edges since the start edge
`include "adc_ctrl_defs.svh"
module adc_sequencer
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   // timing carrier
   conv_if.seq       c
);
   seq_state_e state_q;
   logic [4:0] cyc_q;
   logic       first_q;     // next conversion is an extended one
   logic       long_q;      // running conversion is an extended one
   logic       done_q;
   logic       hold_q;
   logic       step_q;
   logic [4:0] total_w;
   logic [4:0] sh_w;
   logic       in_sar_w;

   // cycle figures of the running conversion
   assign total_w  = long_q ? `ADC_CYC_FIRST : `ADC_CYC_NORMAL;
   assign sh_w     = long_q ? `ADC_SH_FIRST : `ADC_SH_NORMAL;
   assign in_sar_w = (cyc_q > sh_w) && (cyc_q <= sh_w + 5'd10);
   assign c.busy   = (state_q == SEQ_CONV);
   assign c.last   = c.busy && (cyc_q == total_w - 5'd1);
   assign c.done   = done_q;
   assign c.hold   = hold_q;
   assign c.step   = step_q;

   // conversion cycle state machine
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !c.en) begin
         state_q <= SEQ_IDLE;
         cyc_q   <= '0;
         first_q <= 1'b1;             // re-arm extended conversion
         long_q  <= 1'b0;
         done_q  <= 1'b0;
         hold_q  <= 1'b0;
         step_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         hold_q <= c.fall && c.busy && (cyc_q == sh_w);
         step_q <= c.rise && c.busy && in_sar_w;
         unique case (state_q)
            SEQ_IDLE: begin
               if (c.rise && c.go) begin
                  state_q <= SEQ_CONV;
                  cyc_q   <= '0;
                  long_q  <= first_q;
                  first_q <= 1'b0;
               end
            end
            SEQ_CONV: begin
               if (c.rise) begin
                  if (cyc_q == total_w - 5'd1) begin
                     done_q <= 1'b1;
                     cyc_q  <= '0;
                     long_q <= 1'b0;
                     if (!(c.go && c.free)) begin
                        state_q <= SEQ_IDLE;
                     end
                  end else begin
                     cyc_q <= cyc_q + 5'd1;
                  end
               end
            end
         endcase
      end
   end
endmodule

// >>> hdl/sar_adc_conversion_control.sv
// Purpose: register file and conversion control of a 10-bit sar converter
// Assumes: byte registers on a plain port, read data one cycle later
// Notes:   analog mux, sample-and-hold and comparator sit outside
//
// Our own choices: the address-and-strobe port and the register addresses.
`include "adc_ctrl_defs.svh"
module sar_adc_conversion_control
   import adc_ctrl_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 3
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   // interrupt request
   output logic                   irq_o,
   // analog front end
   output logic                   analog_en_o,
   output ref_src_e               ref_sel_o,
   output logic      [3:0]        chan_sel_o,
   output logic                   sample_hold_o,
   output code_t                  dac_code_o,
   input  wire logic              comp_i
);
   if (DATA_W != 8 || ADDR_W < 2) begin : g_chk
      $error("sar_adc_conversion_control needs DATA_W 8, ADDR_W >= 2");
   end

   conv_if c ();

   // software-visible state
   logic [7:0] insel_q;         // temporary input select register
   logic       en_q;
   logic       start_q;
   logic       free_q;
   logic       flag_q;
   logic       ie_q;
   logic [2:0] ps_q;
   code_t      result_q;
   logic       lock_q;          // data bytes blocked after low read

   // front end state
   ref_src_e   ref_q;
   logic [3:0] chan_q;
   code_t      sar_q;
   code_t      ptr_q;           // one-hot trial bit
   logic       hold_q;
   logic       irq_q;
   logic [7:0] rdata_q;

   // address decode
   logic       hit_insel_w;
   logic       hit_ctrl_w;
   logic       hit_lo_w;
   logic       hit_hi_w;
   logic       wr_insel_w;
   logic       wr_ctrl_w;
   logic       rd_lo_w;
   logic       rd_hi_w;

   assign hit_insel_w = (addr_i == ADDR_W'(`ADC_OFF_INSEL));
   assign hit_ctrl_w  = (addr_i == ADDR_W'(`ADC_OFF_CTRL));
   assign hit_lo_w    = (addr_i == ADDR_W'(`ADC_OFF_RES_LO));
   assign hit_hi_w    = (addr_i == ADDR_W'(`ADC_OFF_RES_HI));
   assign wr_insel_w  = wr_i && hit_insel_w;
   assign wr_ctrl_w   = wr_i && hit_ctrl_w;
   assign rd_lo_w     = rd_i && hit_lo_w;
   assign rd_hi_w     = rd_i && hit_hi_w;

   // fields of the temporary input select register
   logic [1:0] ref_fld_w;
   logic       left_w;
   logic [3:0] ch_fld_w;

   assign ref_fld_w = insel_q[`ADC_INSEL_REF_HI:`ADC_INSEL_REF_LO];
   assign left_w    = insel_q[`ADC_INSEL_LEFT];
   assign ch_fld_w  = insel_q[`ADC_INSEL_CH_HI:`ADC_INSEL_CH_LO];

   // channel decode: pins, bandgap, ground; unused codes fall to ground
   logic [3:0] ch_map_w;
   assign ch_map_w = (ch_fld_w[3] == 1'b0)         ? ch_fld_w :
                     (ch_fld_w == `ADC_CH_BANDGAP) ? `ADC_CH_BANDGAP :
                                                     `ADC_CH_GROUND;

   // reference decode; the reserved code falls back to the pin
   ref_src_e ref_map_w;
   assign ref_map_w = (ref_fld_w == REF_RESERVED) ? REF_EXT_PIN
                                                  : ref_src_e'(ref_fld_w);

   // selections track the temporary register only when safe
   logic track_w;
   assign track_w = en_q && (!c.busy || c.last);

   // fields of a control write
   logic       w_en_w;
   logic       w_start_w;
   logic       w_flag_w;

   assign w_en_w    = wdata_i[`ADC_CTRL_EN];
   assign w_start_w = wdata_i[`ADC_CTRL_START];
   assign w_flag_w  = wdata_i[`ADC_CTRL_FLAG];

   // carrier drive toward prescaler and sequencer
   assign c.en   = en_q;
   assign c.ps   = ps_q;
   assign c.go   = start_q;
   assign c.free = free_q;

   // next value of the start bit
   logic start_d;
   always_comb begin
      start_d = start_q;
      if (c.done && !free_q) begin
         start_d = 1'b0;
      end
      if (wr_ctrl_w && w_start_w && w_en_w) begin
         start_d = 1'b1;
      end
      if (wr_ctrl_w ? !w_en_w : !en_q) begin
         start_d = 1'b0;                         // abort, or start refused
      end
   end

   // next value of the completion flag; set wins over clear
   logic flag_d;
   assign flag_d = c.done
                 | (flag_q && !(wr_ctrl_w && w_flag_w));

   // input select register and control bits
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         insel_q <= `ADC_INSEL_RST;
         en_q    <= 1'(`ADC_CTRL_RST >> `ADC_CTRL_EN);
         free_q  <= 1'b0;
         ie_q    <= 1'b0;
         ps_q    <= 3'h0;
      end else begin
         if (wr_insel_w) begin
            insel_q <= wdata_i & `ADC_INSEL_WMASK;
         end
         if (wr_ctrl_w) begin
            en_q   <= w_en_w;
            free_q <= wdata_i[`ADC_CTRL_FREE];
            ie_q   <= wdata_i[`ADC_CTRL_IE];
            ps_q   <= wdata_i[`ADC_CTRL_PS_HI:`ADC_CTRL_PS_LO];
         end
      end
   end

   // start bit, flag and interrupt request
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         start_q <= 1'b0;
         flag_q  <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         start_q <= start_d;                    // held through free run
         flag_q  <= flag_d;
         irq_q   <= flag_d && (wr_ctrl_w ? wdata_i[`ADC_CTRL_IE]
                                         : ie_q);
      end
   end

   // applied channel and reference, frozen mid-conversion
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ref_q  <= REF_EXT_PIN;
         chan_q <= 4'h0;
      end else if (track_w) begin
         ref_q  <= ref_map_w;
         chan_q <= ch_map_w;
      end
   end

   // successive approximation register against the comparator
   code_t ptr_next_w;
   code_t sar_keep_w;
   assign ptr_next_w = ptr_q >> 1;
   assign sar_keep_w = comp_i ? sar_q : (sar_q & ~ptr_q);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         sar_q  <= '0;
         ptr_q  <= '0;
         hold_q <= 1'b0;
      end else begin
         hold_q <= c.hold;
         if (c.hold) begin
            sar_q <= `ADC_SAR_MSB;               // first trial at mid scale
            ptr_q <= `ADC_SAR_MSB;
         end else if (c.step && ptr_q != '0) begin
            sar_q <= sar_keep_w | ptr_next_w;
            ptr_q <= ptr_next_w;
         end
      end
   end

   // result bytes and the read lock
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         result_q <= '0;
         lock_q   <= 1'b0;
      end else begin
         if (c.done && !lock_q && !rd_lo_w) begin
            result_q <= sar_q;
         end
         if (rd_lo_w) begin
            lock_q <= 1'b1;
         end else if (rd_hi_w) begin
            lock_q <= 1'b0;
         end
      end
   end

   // justified views of the result
   logic [7:0] res_lo_w;
   logic [7:0] res_hi_w;
   assign res_lo_w = left_w ? {result_q[1:0], 6'h00}
                            : result_q[7:0];
   assign res_hi_w = left_w ? result_q[9:2]
                            : {6'h00, result_q[9:8]};

   // read data mux; unmapped offsets read zero
   logic [7:0] ctrl_rd_w;
   logic [7:0] rd_mux_w;
   assign ctrl_rd_w = {en_q, start_q, free_q, flag_q, ie_q, ps_q};
   assign rd_mux_w  = hit_insel_w ? insel_q :
                      hit_ctrl_w  ? ctrl_rd_w :
                      hit_lo_w    ? res_lo_w :
                      hit_hi_w    ? res_hi_w : 8'h00;

   // read data stand for one cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_i ? rd_mux_w : 8'h00;
      end
   end

   // timing submodules
   adc_prescaler #(
      .DIV_W (7)
   ) u_presc (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .c         (c)
   );

   adc_sequencer u_seq (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .c         (c)
   );

   // outputs straight from flip-flops
   assign rdata_o       = rdata_q;
   assign irq_o         = irq_q;
   assign analog_en_o   = en_q;
   assign ref_sel_o     = ref_q;
   assign chan_sel_o    = chan_q;
   assign sample_hold_o = hold_q;
   assign dac_code_o    = sar_q;
endmodule

// >>> bench/adc_ctrl_assertions.sv
// Purpose: port-level checks of the converter control
// Assumes: register map and field positions of adc_ctrl_defs.svh
// Notes:   bound onto every instance of the top module
`include "adc_ctrl_defs.svh"
module adc_ctrl_assertions
   import adc_ctrl_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 3
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [DATA_W-1:0] rdata_o,
   // converter side
   input  wire logic              irq_o,
   input  wire logic              analog_en_o,
   input  ref_src_e               ref_sel_o,
   input  wire logic [3:0]        chan_sel_o,
   input  wire logic              sample_hold_o,
   input  code_t                  dac_code_o,
   input  wire logic              comp_i
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   logic left_q;
   // strobe decodes
   wire  wr_sel = wr_i && addr_i == `ADC_OFF_INSEL;
   wire  wr_ctl = wr_i && addr_i == `ADC_OFF_CTRL;
   wire  rd_ctl = rd_i && addr_i == `ADC_OFF_CTRL;

   // mirror of the left adjust bit
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         left_q <= 1'b0;
      end else if (wr_sel) begin
         left_q <= wdata_i[`ADC_INSEL_LEFT];
      end
   end

   sh_pulse_a: assert property (sample_hold_o |=> !sample_hold_o)
      else $error("sample pulse longer than one cycle");
   sel_frozen_a: assert property (sample_hold_o |=>
      (($stable(chan_sel_o) && $stable(ref_sel_o)) || !analog_en_o)[*8])
      else $error("selection moved during conversion");
   first_conv_a: assert property ($rose(analog_en_o) |->
      !sample_hold_o[*8]) else $error("first sample too early");
   en_write_a: assert property (wr_ctl |=>
      analog_en_o == $past(wdata_i[`ADC_CTRL_EN]))
      else $error("enable not applied");
   irq_off_a: assert property (wr_ctl && !wdata_i[`ADC_CTRL_IE] |=>
      !irq_o) else $error("irq without enable");
   idle_start_a: assert property (!analog_en_o && wr_ctl &&
      !wdata_i[`ADC_CTRL_EN] |=> !sample_hold_o[*8])
      else $error("conversion while disabled");
   right_adj_a: assert property (rd_i && addr_i == `ADC_OFF_RES_HI &&
      !left_q |=> rdata_o[7:2] == 6'h00) else $error("high byte not right");
   left_adj_a: assert property (rd_i && addr_i == `ADC_OFF_RES_LO &&
      left_q |=> rdata_o[5:0] == 6'h00) else $error("low byte not left");
   ctrl_en_a: assert property (rd_ctl |=>
      rdata_o[`ADC_CTRL_EN] == $past(analog_en_o))
      else $error("enable bit reads wrong");
   start_busy_a: assert property (sample_hold_o ##[0:8] rd_ctl |=>
      rdata_o[`ADC_CTRL_START]) else $error("start bit low mid conversion");

   // main scenarios
   cover property (sample_hold_o);
   cover property (irq_o);
   cover property (rd_i && addr_i == `ADC_OFF_RES_HI && left_q);
endmodule

bind sar_adc_conversion_control adc_ctrl_assertions #(
   .DATA_W(DATA_W), .ADDR_W(ADDR_W)
) chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .irq_o(irq_o), .analog_en_o(analog_en_o), .ref_sel_o(ref_sel_o),
   .chan_sel_o(chan_sel_o), .sample_hold_o(sample_hold_o),
   .dac_code_o(dac_code_o), .comp_i(comp_i)
);

// >>> bench/adc_front_model.sv
// Purpose: analog mux, sample-and-hold and comparator of the converter
// Assumes: comparator answers 1 when the held level >= trial code
// Notes:   unpowered comparator toggles so no stale value can help
module adc_front_model
   import adc_ctrl_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       en_i,
   input  wire logic [3:0] chan_i,
   input  wire logic       hold_i,
   input  code_t           dac_i,
   output logic            comp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   code_t held_q;
   code_t level;
   logic  tog_q = 1'b0;

   // input level: pins ramp, top pin at full scale, ground zero
   always_comb begin
      case (chan_i)
         4'h7:    level = 10'h3ff;
         4'he:    level = 10'h1e0;
         4'hf:    level = 10'h000;
         default: level = 10'(chan_i[2:0] * 10'h071 + 10'h00b);
      endcase
   end

   // hold the level at the sample instant
   always @(posedge ref_clk_i) begin
      tog_q <= ~tog_q;
      if (hold_i) begin
         held_q <= level;
      end
   end

   // comparator against the trial code
   assign comp_o = en_i ? (held_q >= dac_i) : tog_q;
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench of the converter control
// Assumes: divide 2,2,4,8.. per prescaler select; 10 MHz clock
// Notes:   conversions run against adc_front_model
`include "adc_ctrl_defs.svh"
module tb
   import adc_ctrl_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] sel;  // input select written
      logic [3:0] chan; // applied channel expected
      logic [1:0] refs; // applied reference expected
   } row_s;
   logic       ref_clk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic       irq_o;
   logic       analog_en_o;
   ref_src_e   ref_sel_o;
   logic [3:0] chan_sel_o;
   logic       sample_hold_o;
   code_t      dac_code_o;
   logic       comp_i;
   logic [7:0] d;
   int         miscompares = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         n;
   int         dv;
   row_s       rows [12] = '{
      '{8'h00, 4'h0, 2'h0}, '{8'h61, 4'h1, 2'h1}, '{8'hc2, 4'h2, 2'h3},
      '{8'ha3, 4'h3, 2'h0}, '{8'h44, 4'h4, 2'h1}, '{8'h25, 4'h5, 2'h0},
      '{8'hc6, 4'h6, 2'h3}, '{8'h67, 4'h7, 2'h1}, '{8'h0e, 4'he, 2'h0},
      '{8'h2f, 4'hf, 2'h0}, '{8'h49, 4'hf, 2'h1}, '{8'hed, 4'hf, 2'h3}};
   logic [2:0] ps_tab [3] = '{3'h0, 3'h2, 3'h6};

   sar_adc_conversion_control uut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .irq_o(irq_o), .analog_en_o(analog_en_o), .ref_sel_o(ref_sel_o),
      .chan_sel_o(chan_sel_o), .sample_hold_o(sample_hold_o),
      .dac_code_o(dac_code_o), .comp_i(comp_i));
   adc_front_model fe (
      .ref_clk_i(ref_clk_i), .en_i(analog_en_o), .chan_i(chan_sel_o),
      .hold_i(sample_hold_o), .dac_i(dac_code_o), .comp_o(comp_i));

   always #50 ref_clk_i = ~ref_clk_i;

   // cut a hang short
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         end_sim();
      end
   end

   function automatic code_t lvl(input logic [3:0] ch);
      if (ch == 4'h7) return 10'h3ff;
      if (ch == 4'he) return 10'h1e0;
      if (ch > 4'h7) return 10'h000;
      return 10'(ch * 10'h071 + 10'h00b);
   endfunction

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
      @(negedge ref_clk_i);
      d = rdata_o;
   endtask

   // counts clocks until irq (which=1) or the sample pulse is seen
   task automatic wait_hi(input bit which, output int k);
      k = 0;
      do begin
         @(negedge ref_clk_i);
         k++;
      end while ((which ? irq_o : sample_hold_o) !== 1'b1 && k < 5000);
      if (k >= 5000) miscompares++;
   endtask

   task automatic convert(input logic [7:0] sel);
      wr(`ADC_OFF_INSEL, sel);
      wr(`ADC_OFF_CTRL, 8'hd8);
      wait_hi(1'b1, n);
   endtask

   task automatic chk_res(input logic left, input logic [3:0] ch);
      code_t e;
      e = lvl(ch);
      rd(`ADC_OFF_RES_LO);
      chk(d, left ? {e[1:0], 6'h00} : e[7:0]);
      rd(`ADC_OFF_RES_HI);
      chk(d, left ? e[9:2] : {6'h00, e[9:8]});
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      // reset values; result and unmapped writes are ignored
      wr(`ADC_OFF_RES_LO, 8'hff);
      wr(`ADC_OFF_RES_HI, 8'hff);
      wr(3'h5, 8'hff);
      for (int a = 0; a < 6; a++) begin
         rd(3'(a));
         chk(d, 8'h00);
      end
      chk({analog_en_o, chan_sel_o, ref_sel_o}, 7'h00);
      $display("test reset done");
      // table of channels, references and adjustments
      wr(`ADC_OFF_CTRL, 8'h80);
      foreach (rows[i]) begin
         convert(rows[i].sel);
         chk(chan_sel_o, rows[i].chan);
         chk(ref_sel_o, rows[i].refs);
         chk_res(rows[i].sel[5], rows[i].chan);
         rd(`ADC_OFF_CTRL);
         chk(d, 8'h98);
      end
      $display("test rows done");
      // low read locks; discarded result still raises irq
      convert(8'h07);
      rd(`ADC_OFF_RES_LO);
      convert(8'h02);
      rd(`ADC_OFF_RES_HI);
      chk(d, 8'h03);
      convert(8'h02);
      chk_res(1'b0, 4'h2);
      $display("test lock done");
      // channel change in mid conversion
      wr(`ADC_OFF_INSEL, 8'h04);
      wr(`ADC_OFF_CTRL, 8'hd8);
      wait_hi(1'b0, n);
      chk(n >= 2 && n <= 10, 1'b1);
      wr(`ADC_OFF_INSEL, 8'h01);
      chk(chan_sel_o, 4'h4);
      wait_hi(1'b1, n);
      chk(chan_sel_o, 4'h1);
      chk_res(1'b0, 4'h4);
      $display("test channel change done");
      // start without enable is refused
      wr(`ADC_OFF_CTRL, 8'h10);
      wr(`ADC_OFF_CTRL, 8'h40);
      repeat (60) @(posedge ref_clk_i);
      rd(`ADC_OFF_CTRL);
      chk(d, 8'h00);
      $display("test refused start done");
      // free run per prescaler; ps 6 keeps the clock near 156 kHz
      foreach (ps_tab[j]) begin
         dv = (ps_tab[j] == 3'h0) ? 2 : (1 << ps_tab[j]);
         wr(`ADC_OFF_CTRL, 8'h00);
         wr(`ADC_OFF_CTRL, {5'h1c, ps_tab[j]});
         wait_hi(1'b0, n);
         chk(n >= 12 * dv && n <= 16 * dv + 4, 1'b1);
         wait_hi(1'b0, n);
         chk(n, 13 * dv);
         wait_hi(1'b0, n);
         chk(n, 13 * dv);
         rd(`ADC_OFF_CTRL);
         chk(d[7:4], 4'hf);
      end
      wr(`ADC_OFF_CTRL, 8'h00);
      $display("test free run done");
      end_sim();
   end
endmodule
